// ### sslc_serial_latch.v
// serial shift chain, write-command check, idle latch detector and data latch
// Behaviour
// - shift edge loads input bit, shifts up
// - chain top bit drives serial output
// - top six bits command, rest payload
// - latch copies payload only on 25h
// - chain has no power-up value
// - latch undefined except blank set
// - low 192 bits are twelve grayscale words
// - three seven-bit colour brightness fields
// - blank forces outputs off, counter reset
// - auto repeat selects one or continuous cycles
// - timing reset restarts counter on latch
// - clock select picks oscillator or shift clock
// - edge select picks rising or falling edge
// - latch after idle eight times last interval
// - idle timeout clamped eight to 16384 ticks
// - counter held zero while blanked
`timescale 1ns/10ps
`default_nettype none
`include "sslc_map.vh"
module sslc_serial_latch #(
    parameter OSC_DIV = `SSLC_OSC_DIV,
    parameter IDLE_MAX = `SSLC_IDLE_MAX_OSC
) (
    // clock and reset
    input wire i_clk_sys,
    input wire i_rst_n,
    // serial link pins
    input wire i_ser_data_in,
    input wire i_shift_clk_in,
    output wire o_ser_data_out,
    // latched grayscale words, red0 in low bits
    output wire [`SSLC_GRAY_TOP:0] o_grayscale,
    // colour group brightness
    output wire [`SSLC_BRT_W-1:0] o_bright_red_grp,
    output wire [`SSLC_BRT_W-1:0] o_bright_green_grp,
    output wire [`SSLC_BRT_W-1:0] o_bright_blue_grp,
    // function control towards pwm engine
    output wire o_blank,
    output wire o_auto_repeat_en,
    output wire o_timing_reset_en,
    output wire o_ref_clk_select,
    output wire o_switch_edge_select,
    // latch event and pwm-engine counter clear request (held while blanked, pulsed on a timing reset latch)
    output reg o_latch_pulse,
    output reg o_gray_counter_clear
);
    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    reg sck_s1;
    reg sck_s2;
    reg sck_s3;
    reg sdi_s1;
    reg sdi_s2;
    wire sck_rise;
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            sdi_s1 <= 1'b0;
            sdi_s2 <= 1'b0;
        end else begin
            sck_s1 <= i_shift_clk_in;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            sdi_s1 <= i_ser_data_in;
            sdi_s2 <= sdi_s1;
        end
    end
    assign sck_rise = sck_s2 && !sck_s3;

    // --------------------------------------------------------------
    // sampled bits pass a fifo before entering the chain
    // --------------------------------------------------------------
    // the chain always drains, so the fifo only absorbs skew between
    // capture and shift; a held ready would mean a lost edge
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_bit;
    wire fifo_out_ready;
    assign fifo_out_ready = 1'b1;
    sslc_fifo #(
        .WIDTH(1),
        .DEPTH(4),
        .AW(2)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_in_valid(sck_rise),
        .o_in_ready(fifo_in_ready),
        .i_in_data(sdi_s2),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_bit)
    );

    // --------------------------------------------------------------
    // shift chain
    // --------------------------------------------------------------
    // no reset: contents undefined until shifted
    reg [`SSLC_SHIFT_W-1:0] serial_input_shift_chain;
    always @(posedge i_clk_sys) begin
        if (fifo_out_valid) begin
            serial_input_shift_chain <= {serial_input_shift_chain[`SSLC_SHIFT_W-2:0],
                                         fifo_bit};
        end
    end
    assign o_ser_data_out = serial_input_shift_chain[`SSLC_SHIFT_W-1];
    wire [5:0] cmd_bits;
    assign cmd_bits = serial_input_shift_chain[`SSLC_CMD_MSB:`SSLC_CMD_LSB];
    wire cmd_ok;
    assign cmd_ok = (cmd_bits == `SSLC_CMD_WRITE);

    // --------------------------------------------------------------
    // oscillator tick and interval measurement
    // --------------------------------------------------------------
    reg [3:0] div_cnt;
    wire osc_tick;
    assign osc_tick = (div_cnt == OSC_DIV[3:0] - 4'h1);
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_cnt <= 4'h0;
        end else if (osc_tick) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // floor of the idle timeout, held at the width of the limit
    localparam [17:0] IDLE_MIN = `SSLC_IDLE_MIN_OSC;
    function [17:0] sslc_clamp;
        input [17:0] val;
        begin
            if (val < IDLE_MIN) begin
                sslc_clamp = IDLE_MIN;
            end else if (val > IDLE_MAX) begin
                sslc_clamp = IDLE_MAX[17:0];
            end else begin
                sslc_clamp = val;
            end
        end
    endfunction

    // --------------------------------------------------------------
    // latch detector
    // --------------------------------------------------------------
    // idle: no edge since the last decision; timing: edges arrive and
    // the idle time is compared; fire: the cycle after the latch decision
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_TIMING = 3'b010;
    localparam [2:0] ST_FIRE = 3'b100;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [14:0] interval_cnt;
    reg [17:0] idle_limit;
    reg [17:0] idle_cnt;
    wire idle_done;
    wire fire_now;
    wire latch_take;
    // the first tick after an edge may be partial, so the limit counts
    // as reached only once that many whole ticks have passed; this keeps
    // the shortest timeout at or above its floor
    assign idle_done = osc_tick && (idle_cnt >= idle_limit);
    assign fire_now = (state == ST_TIMING) && !sck_rise && idle_done;
    assign latch_take = o_latch_pulse && cmd_ok;
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (sck_rise) begin
                    next_state = ST_TIMING;
                end
            end
            ST_TIMING: begin
                if (fire_now) begin
                    next_state = ST_FIRE;
                end
            end
            ST_FIRE: begin
                if (sck_rise) begin
                    next_state = ST_TIMING;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            interval_cnt <= 15'h0;
            idle_limit <= IDLE_MIN;
            idle_cnt <= 18'h0;
            o_latch_pulse <= 1'b0;
        end else begin
            o_latch_pulse <= fire_now && cmd_ok;
            if (sck_rise) begin
                // interval counted in oscillator ticks, times eight
                idle_limit <= sslc_clamp({interval_cnt, 3'h0});
                interval_cnt <= 15'h0;
                idle_cnt <= 18'h0;
            end else if (osc_tick && (state == ST_TIMING)) begin
                if (interval_cnt != 15'h7fff) begin
                    interval_cnt <= interval_cnt + 15'h1;
                end
                if (!idle_done) begin
                    idle_cnt <= idle_cnt + 18'h1;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // data latch
    // --------------------------------------------------------------
    reg [`SSLC_LATCH_W-1:0] display_control_latch;
    reg blank_bit;
    always @(posedge i_clk_sys) begin
        if (latch_take) begin
            display_control_latch <= serial_input_shift_chain[`SSLC_LATCH_W-1:0];
        end
    end
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            blank_bit <= 1'b1;
        end else if (latch_take) begin
            blank_bit <= serial_input_shift_chain[`SSLC_BIT_BLANK];
        end
    end

    // brightness field of one colour group, lowest bit at lsb
    function [`SSLC_BRT_W-1:0] sslc_bright;
        input [`SSLC_LATCH_W-1:0] lat;
        input integer lsb;
        begin
            sslc_bright = lat[lsb +: `SSLC_BRT_W];
        end
    endfunction
    assign o_grayscale = display_control_latch[`SSLC_GRAY_TOP:0];
    assign o_bright_red_grp = sslc_bright(display_control_latch, `SSLC_BRT_RED_LSB);
    assign o_bright_green_grp = sslc_bright(display_control_latch, `SSLC_BRT_GREEN_LSB);
    assign o_bright_blue_grp = sslc_bright(display_control_latch, `SSLC_BRT_BLUE_LSB);
    assign o_blank = blank_bit;
    assign o_auto_repeat_en = display_control_latch[`SSLC_BIT_REPEAT];
    assign o_timing_reset_en = display_control_latch[`SSLC_BIT_TIMING_RST];
    assign o_ref_clk_select = display_control_latch[`SSLC_BIT_REFSEL];
    assign o_switch_edge_select = display_control_latch[`SSLC_BIT_EDGESEL];

    // --------------------------------------------------------------
    // counter clear request to the pwm engine
    // --------------------------------------------------------------
    // held while blanked so the counter stays at zero; one cycle on a
    // latch with timing reset set (new value of the bit applies)
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_gray_counter_clear <= 1'b1;
        end else begin
            o_gray_counter_clear <= blank_bit ||
                (latch_take &&
                 serial_input_shift_chain[`SSLC_BIT_TIMING_RST]);
        end
    end
endmodule // sslc_serial_latch
`default_nettype wire

// ### sslc_map.vh
// constants for the serial shift and latch controller
`ifndef SSLC_MAP_VH
`define SSLC_MAP_VH
`define SSLC_SHIFT_W 224
`define SSLC_LATCH_W 218
`define SSLC_CMD_MSB 223
`define SSLC_CMD_LSB 218
`define SSLC_CMD_WRITE 6'h25
`define SSLC_GRAY_W 16
`define SSLC_GRAY_TOP 191
`define SSLC_BRT_RED_LSB 192
`define SSLC_BRT_GREEN_LSB 199
`define SSLC_BRT_BLUE_LSB 206
`define SSLC_BRT_W 7
`define SSLC_BIT_BLANK 213
`define SSLC_BIT_REPEAT 214
`define SSLC_BIT_TIMING_RST 215
`define SSLC_BIT_REFSEL 216
`define SSLC_BIT_EDGESEL 217
`define SSLC_OSC_NS 83
`define SSLC_SYS_NS 10
`define SSLC_IDLE_MIN_OSC 8
`define SSLC_IDLE_MAX_OSC 16384
`define SSLC_IDLE_MULT 8
`define SSLC_OSC_DIV 8
`endif

// ### sslc_fifo.v
// small synchronous fifo carrying sampled serial bits
`timescale 1ns/10ps
`default_nettype none
module sslc_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire i_clk_sys,
    input wire i_rst_n,
    // fill side
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    // drain side
    output wire o_out_valid,
    input wire i_out_ready,
    output reg [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    reg out_full;
    wire push;
    wire pop;
    wire load;
    assign o_in_ready = (count != DEPTH[AW:0]);
    assign o_out_valid = out_full;
    assign push = i_in_valid && o_in_ready;
    assign load = (count != {(AW+1){1'b0}}) && (!out_full || i_out_ready);
    assign pop = out_full && i_out_ready;
    always @(posedge i_clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            out_full <= 1'b0;
            o_out_data <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (load) begin
                o_out_data <= mem[rd_ptr];
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !load) begin
                count <= count + 1'b1;
            end else if (!push && load) begin
                count <= count - 1'b1;
            end
            if (load) begin
                out_full <= 1'b1;
            end else if (pop) begin
                out_full <= 1'b0;
            end
        end
    end
endmodule // sslc_fifo
`default_nettype wire

// ### sslc_chk_sva.sv
// concurrent checks on the serial shift and latch block
`timescale 1ns/10ps
`default_nettype none
module sslc_chk #(
    parameter OSC_DIV = 8,
    parameter IDLE_MAX = 16384
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_shift_clk_in,
    input wire logic o_ser_data_out,
    input wire logic [191:0] o_grayscale,
    input wire logic o_blank,
    input wire logic o_timing_reset_en,
    input wire logic o_latch_pulse,
    input wire logic o_gray_counter_clear
);
    logic sck_q;
    logic seen;
    logic pulsed;
    logic [17:0] gap;
    wire edge_w = i_shift_clk_in & ~sck_q;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // gap counts cycles since the last raw shift edge
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sck_q <= 1'b0;
            seen <= 1'b0;
            pulsed <= 1'b0;
            gap <= 18'h0;
        end else begin
            sck_q <= i_shift_clk_in;
            seen <= seen | o_latch_pulse;
            pulsed <= edge_w ? 1'b0 : (pulsed | o_latch_pulse);
            gap <= edge_w ? 18'h0 : gap + {17'h0, ~&gap};
        end
    end
    chk_pulse_width: assert property (o_latch_pulse |=> !o_latch_pulse)
        else $error("latch pulse too long");
    chk_idle_min: assert property (o_latch_pulse |-> gap >= 8 * OSC_DIV)
        else $error("latch too soon after shift edge");
    chk_idle_max: assert property (o_latch_pulse |-> gap <= IDLE_MAX * OSC_DIV + 16)
        else $error("latch too late");
    chk_one_latch: assert property (o_latch_pulse |-> !pulsed)
        else $error("second latch in one gap");
    chk_sdo_shift: assert property ($changed(o_ser_data_out) |-> gap <= 8)
        else $error("serial out moved without shift edge");
    chk_gray_hold: assert property (seen && !$past(o_latch_pulse) |-> $stable(o_grayscale))
        else $error("grayscale changed without latch");
    chk_blank_hold: assert property (!$past(o_latch_pulse) |-> $stable(o_blank))
        else $error("blank changed without latch");
    chk_blank_clear: assert property (o_blank && $past(o_blank) |-> o_gray_counter_clear)
        else $error("counter not cleared while blank");
    chk_trst_clear: assert property (o_latch_pulse ##1 o_timing_reset_en |-> ##[0:2] o_gray_counter_clear)
        else $error("no counter clear on timing reset latch");
    cover property (o_latch_pulse);
    cover property ($fell(o_blank));
    cover property (o_gray_counter_clear && !o_blank);
endmodule // sslc_chk
bind sslc_serial_latch sslc_chk #(.OSC_DIV(OSC_DIV), .IDLE_MAX(IDLE_MAX)) sslc_chk_i (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_shift_clk_in(i_shift_clk_in),
    .o_ser_data_out(o_ser_data_out), .o_grayscale(o_grayscale), .o_blank(o_blank),
    .o_timing_reset_en(o_timing_reset_en), .o_latch_pulse(o_latch_pulse),
    .o_gray_counter_clear(o_gray_counter_clear));
`default_nettype wire

// ### sslc_host_model.sv
// host model shifting packets into the serial link
`timescale 1ns/10ps
`default_nettype none
module sslc_host_model (
    // clock and packet request
    input wire logic i_clk_sys,
    input wire logic i_start,
    input wire logic [223:0] i_pkt,
    output var logic o_busy,
    output var logic [223:0] o_echo,
    // link pins
    input wire logic i_ser_data_out,
    output var logic o_shift_clk_in,
    output var logic o_ser_data_in
);
    logic [7:0] bitn;
    logic [3:0] ph;
    initial begin
        o_busy = 1'b0;
        o_shift_clk_in = 1'b0;
        o_ser_data_in = 1'b0;
    end
    // 16 system cycles per shift period; clock parked low between frames
    always @(posedge i_clk_sys) begin
        if (!o_busy) begin
            ph <= 4'h0;
            bitn <= 8'hdf;
            o_busy <= i_start;
        end else begin
            ph <= ph + 4'h1;
            if (ph == 4'h0) o_ser_data_in <= i_pkt[bitn];
            if (ph == 4'h8) begin
                o_shift_clk_in <= 1'b1;
                o_echo <= {o_echo[222:0], i_ser_data_out};
            end
            if (ph == 4'hf) begin
                o_shift_clk_in <= 1'b0;
                bitn <= bitn - 8'h1;
                o_busy <= (bitn != 8'h0);
            end
            // undriven line shows the inverse, not a stale bit
            if (ph == 4'hf && bitn == 8'h0) o_ser_data_in <= ~o_ser_data_in;
        end
    end
endmodule // sslc_host_model
`default_nettype wire

// ### serial_shift_latch_ctrl_tb_top.sv
// self-checking bench for the serial shift and latch block
`timescale 1ns/10ps
`default_nettype none
module serial_shift_latch_ctrl_tb_top;
    logic clk, rst_n, start, sck, sdi, sdo, busy, pulse, clr, bl, ar, tr, rs, es, good, have;
    logic [223:0] pkt, p, echo;
    logic [191:0] gray;
    logic [6:0] br, bg, bb;
    logic [217:0] exp_l;
    logic [223:0] sent[$];
    integer seed = 53, fail_count = 0, total_checks = 0, cyc = 0, pulses = 0, c, i, k;
    sslc_serial_latch #(.OSC_DIV(8), .IDLE_MAX(64)) sslc_serial_latch_i (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_ser_data_in(sdi), .i_shift_clk_in(sck),
        .o_ser_data_out(sdo), .o_grayscale(gray), .o_bright_red_grp(br),
        .o_bright_green_grp(bg), .o_bright_blue_grp(bb), .o_blank(bl),
        .o_auto_repeat_en(ar), .o_timing_reset_en(tr), .o_ref_clk_select(rs),
        .o_switch_edge_select(es), .o_latch_pulse(pulse), .o_gray_counter_clear(clr));
    sslc_host_model sslc_host_model_i (
        .i_clk_sys(clk), .i_start(start), .i_pkt(pkt), .o_busy(busy), .o_echo(echo),
        .i_ser_data_out(sdo), .o_shift_clk_in(sck), .o_ser_data_in(sdi));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (pulse === 1'b1) pulses++;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            $display("BAD %0t timeout", $time);
            close_out;
        end
    end
    // ----
    // shared tasks
    // ----
    task automatic check(input bit ok, input string m);
        total_checks++;
        if (!ok) begin
            fail_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic send(input logic [223:0] d);
        pkt <= d;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (2) @(posedge clk);
        for (k = 0; k < 4000 && busy; k++) @(posedge clk);
        check(busy === 1'b0, "host frame hung");
        // long enough for the idle timeout of a 16-cycle shift period
        repeat (300) @(posedge clk);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        pkt = 224'h0;
        have = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check(bl === 1'b1 && clr === 1'b1 && pulse === 1'b0, "reset state");
        for (i = 0; i < 7; i++) begin
            for (k = 0; k < 7; k++) p = {p[191:0], $random(seed)};
            if (i % 2 == 0) p[223:218] = 6'h25;
            else if (p[223:218] == 6'h25) p[223:218] = 6'h24;
            if (i == 2) p[215:213] = 3'b100;
            good = (p[223:218] == 6'h25);
            c = pulses;
            send(p);
            sent.push_back(p);
            if (good) exp_l = p[217:0];
            have = have | good;
            check((pulses - c) == (good ? 1 : 0), "latch pulse count");
            if (have) check({es, rs, tr, ar, bl, bb, bg, br, gray} === exp_l, "latch");
            if (sent.size() > 1) check(echo === sent.pop_front(), "cascade out");
            $display("test %0d done", i);
        end
        close_out;
    end
endmodule // serial_shift_latch_ctrl_tb_top
`default_nettype wire
